// ===== rtl/ism_pkg.sv
// constants, types and helpers of the bus status and address mask block
`default_nettype none

package ism_pkg;

   localparam int             APB_AW       = 8;
   localparam logic [7:0]     OFS_STATUS   = 8'h00;
   localparam logic [7:0]     OFS_MASK     = 8'h04;
   localparam logic [7:0]     OFS_OWNADDR  = 8'h08;
   localparam logic [7:0]     OFS_CTRL     = 8'h0C;
   localparam logic [7:0]     OFS_TX       = 8'h10;
   localparam logic [7:0]     OFS_RX       = 8'h14;
   localparam logic [7:0]     OFS_INTSTAT  = 8'h18;
   localparam logic [7:0]     OFS_INTMASK  = 8'h1C;

   localparam int             ST_NACK      = 15;
   localparam int             ST_TXBUSY    = 14;
   localparam int             ST_BCL       = 10;
   localparam int             ST_GC        = 9;
   localparam int             ST_TEN       = 8;
   localparam int             ST_WCOL      = 7;
   localparam int             ST_OVF       = 6;
   localparam int             ST_DA        = 5;
   localparam int             ST_STOP      = 4;
   localparam int             ST_START     = 3;
   localparam int             ST_RW        = 2;
   localparam int             ST_RBF       = 1;
   localparam int             ST_TBF       = 0;

   localparam int             CTRL_A10     = 10;
   localparam int             CTRL_GCEN    = 7;
   localparam logic [15:0]    CTRL_WMASK   = 16'h0480;
   localparam logic [15:0]    ADDR_WMASK   = 16'h03FF;

   localparam logic [15:0]    CTRL_RST     = 16'h0000;
   localparam logic [15:0]    MASK_RST     = 16'h0000;
   localparam logic [15:0]    OWNADDR_RST  = 16'h0000;
   localparam logic [7:0]     TXBYTE_RST   = 8'h00;
   localparam logic [7:0]     RXBYTE_RST   = 8'h00;

   localparam int             INT_W        = 6;
   localparam int             INT_RX       = 0;
   localparam int             INT_BCL      = 1;
   localparam int             INT_OVF      = 2;
   localparam int             INT_WCOL     = 3;
   localparam int             INT_STOP     = 4;
   localparam int             INT_MATCH    = 5;
   localparam logic [5:0]     INT_RST      = 6'h00;

   localparam logic [7:0]     GENCALL_ADDR = 8'h00;
   localparam logic [4:0]     TEN_HDR      = 5'h1E;

   typedef enum logic [2:0] {SLV_IDLE, SLV_ADDR, SLV_TEN_LOW, SLV_DATA, SLV_SKIP} ism_slv_t;

   // masked positions always compare equal
   function automatic logic maskedEq(input logic [9:0] a,
                                     input logic [9:0] b,
                                     input logic [9:0] m);
      maskedEq = ((a ^ b) & ~m) == 10'h000;
   endfunction : maskedEq

endpackage : ism_pkg

`default_nettype wire

// ===== rtl/ism_status_mask.sv
// status flags, address mask compare and apb registers of the two-wire bus controller
//
// The APB register port and the address map were left to the implementer.
`default_nettype none

module ism_status_mask #(
   parameter int ADDR_W = 10
) (
   input  wire logic                      mclk,
   input  wire logic                      arst_n,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ism_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic                           irq,
   input  wire logic                      slaveMode,
   input  wire logic                      engineBusy,
   input  wire logic                      evStart,
   input  wire logic                      evStop,
   input  wire logic                      evCollision,
   input  wire logic                      evMasterTxStart,
   input  wire logic                      evSlaveAck,
   input  wire logic                      ackIsNack,
   input  wire logic                      evRxByte,
   input  wire logic [7:0]                receiveShifter,
   input  wire logic                      evTxDone,
   output logic      [7:0]                txByte,
   output logic                           txPending,
   output logic                           addrMatch,
   output logic                           rxPulse
);
   import ism_pkg::*;

   if (ADDR_W != 10) begin : gen_width_check
      $error("ism_status_mask serves a 10-bit address only");
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   logic        apbSetup;
   logic        apbAcc;
   logic        wrAcc;
   logic        rdAcc;
   logic [7:0]  ofs;
   logic        mapped;
   logic [31:0] rdWord;

   logic        nackReg;
   logic        txBusyReg;
   logic        bclReg;
   logic        gcReg;
   logic        tenReg;
   logic        wcolReg;
   logic        ovfReg;
   logic        daReg;
   logic        stopReg;
   logic        startReg;
   logic        rwReg;
   logic        rbfReg;
   logic        tbfReg;
   logic [15:0] ctrlReg;
   logic [15:0] maskReg;
   logic [15:0] ownAddrReg;
   logic [7:0]  txByteReg;
   logic [7:0]  rxByteReg;
   logic [5:0]  intStatReg;
   logic [5:0]  intMaskReg;
   logic [5:0]  intReadReg;
   logic        rxReadReg;
   ism_slv_t    slvReg;
   ism_slv_t    slvNext;

   assign apbSetup = psel & ~penable;
   assign apbAcc   = psel & penable & pready;
   assign ofs      = paddr[7:0];
   assign wrAcc    = apbAcc & pwrite & mapped;
   assign rdAcc    = apbAcc & ~pwrite & mapped;

   logic [15:0] statusWord;
   always_comb begin
      statusWord            = 16'h0000;
      statusWord[ST_NACK]   = nackReg;
      statusWord[ST_TXBUSY] = txBusyReg;
      statusWord[ST_BCL]    = bclReg;
      statusWord[ST_GC]     = gcReg;
      statusWord[ST_TEN]    = tenReg;
      statusWord[ST_WCOL]   = wcolReg;
      statusWord[ST_OVF]    = ovfReg;
      statusWord[ST_DA]     = daReg;
      statusWord[ST_STOP]   = stopReg;
      statusWord[ST_START]  = startReg;
      statusWord[ST_RW]     = rwReg;
      statusWord[ST_RBF]    = rbfReg;
      statusWord[ST_TBF]    = tbfReg;
   end

   always_comb begin
      mapped = 1'b1;
      rdWord = 32'h0000_0000;
      unique case (ofs)
         OFS_STATUS:  rdWord = {16'h0000, statusWord};
         OFS_MASK:    rdWord = {16'h0000, maskReg};
         OFS_OWNADDR: rdWord = {16'h0000, ownAddrReg};
         OFS_CTRL:    rdWord = {16'h0000, ctrlReg};
         OFS_TX:      rdWord = {24'h000000, txByteReg};
         OFS_RX:      rdWord = {24'h000000, rxByteReg};
         OFS_INTSTAT: rdWord = {26'h0000000, intStatReg};
         OFS_INTMASK: rdWord = {26'h0000000, intMaskReg};
         default:     mapped = 1'b0;
      endcase
   end

   // read data is taken in the setup cycle so that it comes from a flop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata     <= 32'h0000_0000;
         pslverr    <= 1'b0;
         pready     <= 1'b0;
         intReadReg <= INT_RST;
         rxReadReg  <= 1'b0;
      end else begin
         pready  <= apbSetup;
         pslverr <= apbSetup & ~mapped;
         if (apbSetup) begin
            prdata     <= pwrite ? 32'h0000_0000 : rdWord;
            intReadReg <= (!pwrite && ofs == OFS_INTSTAT) ? intStatReg : INT_RST;
            rxReadReg  <= !pwrite && ofs == OFS_RX;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlReg    <= CTRL_RST;
         maskReg    <= MASK_RST;
         ownAddrReg <= OWNADDR_RST;
         intMaskReg <= INT_RST;
      end else if (wrAcc) begin
         if (ofs == OFS_CTRL) ctrlReg <= pwdata[15:0] & CTRL_WMASK;
         if (ofs == OFS_MASK) maskReg <= pwdata[15:0] & ADDR_WMASK;
         if (ofs == OFS_OWNADDR) ownAddrReg <= pwdata[15:0] & ADDR_WMASK;
         if (ofs == OFS_INTMASK) intMaskReg <= pwdata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave address compare

   logic       tenMode;
   logic       gcEnable;
   logic       hit7;
   logic       hitGc;
   logic       hitHdr;
   logic       hitLow;
   logic       addrHit;
   logic       rxAccept;
   logic       rxLoad;
   logic       rxOverflow;
   logic       dataByte;

   assign tenMode  = ctrlReg[CTRL_A10];
   assign gcEnable = ctrlReg[CTRL_GCEN];
   assign hit7     = maskedEq({3'b000, receiveShifter[7:1]},
                              {3'b000, ownAddrReg[6:0]},
                              {3'b000, maskReg[6:0]});
   assign hitGc    = gcEnable & (receiveShifter == GENCALL_ADDR);
   assign hitHdr   = (receiveShifter[7:3] == TEN_HDR) &
                     maskedEq({receiveShifter[2:1], 8'h00},
                              {ownAddrReg[9:8], 8'h00},
                              {maskReg[9:8], 8'h00});
   assign hitLow   = maskedEq({2'b00, receiveShifter},
                              {2'b00, ownAddrReg[7:0]},
                              {2'b00, maskReg[7:0]});

   // a read header only counts once the full 10-bit address matched earlier
   always_comb begin
      slvNext = slvReg;
      addrHit = 1'b0;
      if (!slaveMode) begin
         slvNext = SLV_IDLE;
      end else if (evStop) begin
         slvNext = SLV_IDLE;
      end else if (evStart) begin
         slvNext = SLV_ADDR;
      end else if (evRxByte) begin
         unique case (slvReg)
            SLV_ADDR: begin
               if (tenMode) begin
                  if (hitHdr && !receiveShifter[0]) begin
                     slvNext = SLV_TEN_LOW;
                  end else if (hitHdr && tenReg) begin
                     slvNext = SLV_DATA;
                     addrHit = 1'b1;
                  end else if (hitGc) begin
                     slvNext = SLV_DATA;
                     addrHit = 1'b1;
                  end else begin
                     slvNext = SLV_SKIP;
                  end
               end else if (hit7 || hitGc) begin
                  slvNext = SLV_DATA;
                  addrHit = 1'b1;
               end else begin
                  slvNext = SLV_SKIP;
               end
            end
            SLV_TEN_LOW: begin
               slvNext = hitLow ? SLV_DATA : SLV_SKIP;
               addrHit = hitLow;
            end
            SLV_IDLE, SLV_DATA, SLV_SKIP: slvNext = slvReg;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         slvReg <= SLV_IDLE;
      end else begin
         slvReg <= slvNext;
      end
   end

   assign dataByte   = evRxByte & slaveMode & (slvReg == SLV_DATA) & ~evStart & ~evStop;
   assign rxAccept   = evRxByte & (~slaveMode | addrHit | dataByte);
   assign rxLoad     = rxAccept & ~rbfReg;
   assign rxOverflow = rxAccept & rbfReg;

   ////////////////////////////////////////////////////////////////////////////
   // receive path

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxByteReg <= RXBYTE_RST;
         rxPulse   <= 1'b0;
         addrMatch <= 1'b0;
      end else begin
         rxPulse   <= rxLoad;
         addrMatch <= addrHit;
         if (rxLoad) rxByteReg <= receiveShifter;
      end
   end

   // set wins over the clear of the read
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rbfReg <= 1'b0;
      end else if (rxLoad) begin
         rbfReg <= 1'b1;
      end else if (rdAcc && rxReadReg) begin
         rbfReg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit path

   logic txWrite;
   logic txAccepted;
   assign txWrite    = wrAcc & (ofs == OFS_TX);
   assign txAccepted = txWrite & ~engineBusy;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         txByteReg <= TXBYTE_RST;
      end else if (txAccepted) begin
         txByteReg <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tbfReg <= 1'b0;
      end else if (txAccepted) begin
         tbfReg <= 1'b1;
      end else if (evTxDone) begin
         tbfReg <= 1'b0;
      end
   end

   assign txByte    = txByteReg;
   assign txPending = tbfReg;

   ////////////////////////////////////////////////////////////////////////////
   // status flags

   logic statusWr;
   assign statusWr = wrAcc & (ofs == OFS_STATUS);

   // software clears by writing 0; hardware set wins in the same cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bclReg  <= 1'b0;
         wcolReg <= 1'b0;
         ovfReg  <= 1'b0;
      end else begin
         if (evCollision) bclReg <= 1'b1;
         else if (statusWr && !pwdata[ST_BCL]) bclReg <= 1'b0;
         if (txWrite && engineBusy) wcolReg <= 1'b1;
         else if (statusWr && !pwdata[ST_WCOL]) wcolReg <= 1'b0;
         if (rxOverflow) ovfReg <= 1'b1;
         else if (statusWr && !pwdata[ST_OVF]) ovfReg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nackReg   <= 1'b0;
         txBusyReg <= 1'b0;
      end else begin
         if (evSlaveAck && !slaveMode) nackReg <= ackIsNack;
         if (evMasterTxStart) txBusyReg <= 1'b1;
         else if (evSlaveAck) txBusyReg <= 1'b0;
      end
   end

   // bus events: the latest one wins; a start beside a stop counts as later
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         startReg <= 1'b0;
         stopReg  <= 1'b0;
      end else if (evStart) begin
         startReg <= 1'b1;
         stopReg  <= 1'b0;
      end else if (evStop) begin
         startReg <= 1'b0;
         stopReg  <= 1'b1;
      end else if (statusWr) begin
         if (!pwdata[ST_START]) startReg <= 1'b0;
         if (!pwdata[ST_STOP]) stopReg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gcReg  <= 1'b0;
         tenReg <= 1'b0;
      end else begin
         if (addrHit && hitGc && slvReg == SLV_ADDR) gcReg <= 1'b1;
         else if (evStop) gcReg <= 1'b0;
         if (addrHit && slvReg == SLV_TEN_LOW) tenReg <= 1'b1;
         else if (evStop) tenReg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         daReg <= 1'b0;
         rwReg <= 1'b0;
      end else begin
         if (addrHit) daReg <= 1'b0;
         else if (dataByte) daReg <= 1'b1;
         if (evRxByte && slaveMode && slvReg == SLV_ADDR && !evStart && !evStop) begin
            rwReg <= receiveShifter[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts

   logic [5:0] intSet;
   always_comb begin
      intSet            = INT_RST;
      intSet[INT_RX]    = rxLoad;
      intSet[INT_BCL]   = evCollision;
      intSet[INT_OVF]   = rxOverflow;
      intSet[INT_WCOL]  = txWrite & engineBusy;
      intSet[INT_STOP]  = evStop;
      intSet[INT_MATCH] = addrHit;
   end

   // only bits seen by the read are cleared, so a late event survives
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         intStatReg <= INT_RST;
      end else if (rdAcc && ofs == OFS_INTSTAT) begin
         intStatReg <= (intStatReg & ~intReadReg) | intSet;
      end else begin
         intStatReg <= intStatReg | intSet;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStatReg & intMaskReg);
      end
   end

endmodule : ism_status_mask

`default_nettype wire

// ===== test/ism_engine_model.sv
// engine side model: drives bus events into the status block
`default_nettype none

module ism_engine_model (
   input  wire logic mclk,
   output logic      slaveMode,
   output logic      engineBusy,
   output logic      evStart,
   output logic      evStop,
   output logic      evCollision,
   output logic      evMasterTxStart,
   output logic      evSlaveAck,
   output logic      ackIsNack,
   output logic      evRxByte,
   output logic      [7:0] receiveShifter,
   output logic      evTxDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] ev = 7'h00;
   assign {evStart, evStop, evCollision, evMasterTxStart, evSlaveAck, evRxByte, evTxDone} = ev;
   initial begin
      slaveMode = 1'b0;
      engineBusy = 1'b0;
      ackIsNack = 1'b0;
      receiveShifter = 8'h00;
   end
   task automatic mode(input logic s, input logic b);
      slaveMode <= s;
      engineBusy <= b;
      @(posedge mclk);
   endtask : mode
   // data lines no longer valid after the pulse show the inverse, never a stale copy
   task automatic pulse(input logic [6:0] k, input logic [7:0] b, input logic nk);
      ev <= k;
      receiveShifter <= b;
      ackIsNack <= nk;
      @(posedge mclk);
      ev <= 7'h00;
      receiveShifter <= ~b;
      ackIsNack <= ~nk;
      @(posedge mclk);
   endtask : pulse
endmodule : ism_engine_model

`default_nettype wire

// ===== test/ism_status_mask_sva.sv
// port assertions of the bus status and address mask block
`default_nettype none

module ism_status_mask_sva import ism_pkg::*; #(
   parameter int ADDR_W = 10
) (
   input wire logic              mclk,
   input wire logic              arst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              engineBusy,
   input wire logic              evRxByte,
   input wire logic              evTxDone,
   input wire logic [7:0]        txByte,
   input wire logic              txPending,
   input wire logic              addrMatch,
   input wire logic              rxPulse
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic acc;
   logic txWr;
   assign acc = psel && penable && pready;
   assign txWr = acc && pwrite && paddr == OFS_TX;
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_unmapped: assert property (psel && !penable && (paddr > 8'h1C || paddr[1:0] != 2'b00)
      |=> pslverr) else $error("unmapped access without error");
   chk_tx_load: assert property (txWr && !engineBusy |=> txPending && txByte == $past(pwdata[7:0]))
      else $error("transmit write not taken");
   chk_tx_drop: assert property (txWr && engineBusy |=> $stable(txByte))
      else $error("busy transmit write not dropped");
   chk_tx_done: assert property (evTxDone && !txWr |=> !txPending)
      else $error("transmit full not cleared");
   chk_rx_cause: assert property (rxPulse |-> $past(evRxByte))
      else $error("receive pulse without byte");
   chk_match_cause: assert property (addrMatch |-> $past(evRxByte))
      else $error("match without byte");
   chk_status_zero: assert property (acc && !pwrite && paddr == OFS_STATUS |->
      prdata[31:16] == 16'h0000 && prdata[13:11] == 3'h0) else $error("status spare bits set");
   chk_mask_zero: assert property (acc && !pwrite && paddr == OFS_MASK |->
      prdata[31:10] == 22'h000000) else $error("mask upper bits set");
endmodule : ism_status_mask_sva

bind ism_status_mask ism_status_mask_sva #(.ADDR_W(ADDR_W)) i_sva (.mclk, .arst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .engineBusy, .evRxByte,
   .evTxDone, .txByte, .txPending, .addrMatch, .rxPulse);

`default_nettype wire

// ===== test/ism_status_mask_tb.sv
// self-checking bench of the bus status and address mask block
`default_nettype none

module ism_status_mask_tb import ism_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] E_START = 7'h40, E_STOP = 7'h20, E_COL = 7'h10, E_MTX = 7'h08,
      E_ACK = 7'h04, E_RX = 7'h02, E_TXD = 7'h01;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq, slaveMode, engineBusy;
   logic        evStart, evStop, evCollision, evMasterTxStart, evSlaveAck, ackIsNack;
   logic        evRxByte, evTxDone, txPending, addrMatch, rxPulse, e;
   logic [7:0]  paddr, receiveShifter, txByte;
   logic [31:0] pwdata, prdata, r, d;
   logic [9:0]  m, a;
   int          n_errors = 0;
   int          tests_run = 0;
   int          seed = 56630;
   int          j;
   int          nRx = 0;
   int          nMatch = 0;
   int          nHit = 0;

   ism_status_mask #(.ADDR_W(10)) i_dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq, .slaveMode, .engineBusy, .evStart, .evStop,
      .evCollision, .evMasterTxStart, .evSlaveAck, .ackIsNack, .evRxByte, .receiveShifter,
      .evTxDone, .txByte, .txPending, .addrMatch, .rxPulse);
   ism_engine_model i_eng (.mclk, .slaveMode, .engineBusy, .evStart, .evStop, .evCollision,
      .evMasterTxStart, .evSlaveAck, .ackIsNack, .evRxByte, .receiveShifter, .evTxDone);

   always #25 mclk = ~mclk;

   // one-cycle pulses are counted at the edge that samples them
   always @(posedge mclk) begin
      if (rxPulse === 1'b1) nRx++;
      if (addrMatch === 1'b1) nMatch++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // the request stands until pready is sampled high; the wait is checked to be one cycle
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      chk(n, 1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic look(input logic [7:0] ad, input logic [31:0] msk, input logic [31:0] v);
      apb(1'b0, ad, 32'h0);
      chk(r & msk, v);
   endtask : look

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      #(8000 * 50);
      n_errors++;
      finish_test();
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      look(OFS_STATUS, ALL, 32'h0);
      look(OFS_MASK, ALL, 32'h0);
      look(8'h20, ALL, 32'h0);
      chk(e, 1'b1);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         apb(1'b1, OFS_MASK, d);
         look(OFS_MASK, ALL, d & 32'h3FF);
      end
      done("registers");
      i_eng.pulse(E_START, 8'h00, 1'b0);
      look(OFS_STATUS, 32'h18, 32'h08);
      i_eng.pulse(E_STOP, 8'h00, 1'b0);
      look(OFS_STATUS, 32'h18, 32'h10);
      for (int k = 1; k >= 0; k--) begin
         i_eng.pulse(E_MTX, 8'h00, 1'b0);
         look(OFS_STATUS, 32'h4000, 32'h4000);
         i_eng.pulse(E_ACK, 8'h00, k[0]);
         look(OFS_STATUS, 32'hC000, {k[0], 15'h0});
      end
      i_eng.pulse(E_COL, 8'h00, 1'b0);
      i_eng.pulse(E_STOP, 8'h00, 1'b0);
      look(OFS_STATUS, 32'h400, 32'h400);
      apb(1'b1, OFS_STATUS, 32'hFBFF);
      look(OFS_STATUS, 32'h410, 32'h010);
      done("master");
      d = $random(seed);
      apb(1'b1, OFS_TX, d);
      chk(txByte, d[7:0]);
      look(OFS_STATUS, 32'h81, 32'h01);
      i_eng.mode(1'b0, 1'b1);
      apb(1'b1, OFS_TX, ~d);
      look(OFS_STATUS, 32'h81, 32'h81);
      chk(txByte, d[7:0]);
      i_eng.mode(1'b0, 1'b0);
      i_eng.pulse(E_TXD, 8'h00, 1'b0);
      apb(1'b1, OFS_STATUS, 32'hFF7F);
      look(OFS_STATUS, 32'h81, 32'h00);
      done("transmit");
      apb(1'b1, OFS_INTMASK, 32'h3F);
      apb(1'b0, OFS_INTSTAT, 32'h0);
      i_eng.pulse(E_RX, d[7:0], 1'b0);
      @(posedge mclk);
      chk(irq, 1'b1);
      i_eng.pulse(E_RX, ~d[7:0], 1'b0);
      look(OFS_STATUS, 32'h42, 32'h42);
      look(OFS_RX, ALL, {24'h0, d[7:0]});
      look(OFS_STATUS, 32'h02, 32'h00);
      look(OFS_INTSTAT, 32'h3F, 32'h05);
      @(posedge mclk);
      chk(irq, 1'b0);
      apb(1'b1, OFS_STATUS, 32'hFFBF);
      apb(1'b1, OFS_INTMASK, 32'h0);
      i_eng.pulse(E_RX, d[7:0], 1'b0);
      @(posedge mclk);
      chk(irq, 1'b0);
      look(OFS_RX, 32'hFF, d[7:0]);
      done("receive");
      i_eng.mode(1'b1, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h0);
      for (int i = 0; i < 8; i++) begin
         a = 10'($random(seed));
         m = 10'($random(seed));
         j = {$random(seed)} % 7;
         d = $random(seed);
         apb(1'b1, OFS_OWNADDR, {22'h0, a});
         apb(1'b1, OFS_MASK, {22'h0, m});
         apb(1'b0, OFS_INTSTAT, 32'h0);
         i_eng.pulse(E_START, 8'h00, 1'b0);
         i_eng.pulse(E_RX, {a[6:0] ^ (7'h01 << j), d[0]}, 1'b0);
         look(OFS_INTSTAT, 32'h20, {26'h0, m[j], 5'h0});
         if (m[j]) begin
            look(OFS_STATUS, 32'h24, {29'h0, d[0], 2'b00});
            apb(1'b0, OFS_RX, 32'h0);
            i_eng.pulse(E_RX, d[15:8], 1'b0);
            look(OFS_STATUS, 32'h20, 32'h20);
            nHit++;
         end
         apb(1'b0, OFS_RX, 32'h0);
         i_eng.pulse(E_STOP, 8'h00, 1'b0);
      end
      done("address mask");
      apb(1'b1, OFS_CTRL, 32'h80);
      i_eng.pulse(E_START, 8'h00, 1'b0);
      i_eng.pulse(E_RX, GENCALL_ADDR, 1'b0);
      look(OFS_STATUS, 32'h200, 32'h200);
      apb(1'b0, OFS_RX, 32'h0);
      i_eng.pulse(E_STOP, 8'h00, 1'b0);
      look(OFS_STATUS, 32'h210, 32'h010);
      apb(1'b1, OFS_CTRL, 32'h400);
      apb(1'b1, OFS_MASK, 32'h0);
      i_eng.pulse(E_START, 8'h00, 1'b0);
      i_eng.pulse(E_RX, {TEN_HDR, a[9:8], 1'b0}, 1'b0);
      apb(1'b0, OFS_RX, 32'h0);
      i_eng.pulse(E_RX, a[7:0], 1'b0);
      look(OFS_STATUS, 32'h100, 32'h100);
      apb(1'b0, OFS_RX, 32'h0);
      i_eng.pulse(E_STOP, 8'h00, 1'b0);
      look(OFS_STATUS, 32'h100, 32'h0);
      done("general call and ten bit");
      chk(nRx, 4 + 2 * nHit);
      chk(nMatch, 2 + nHit);
      finish_test();
   end
endmodule : ism_status_mask_tb

`default_nettype wire
